// file: rtl/dram_cycle_regs.vh
// Behaviour
// - Time read, word or byte write, refresh cycles, and read-modify-write transactions.
// - Master drives address then sync; address captured at sync edge, held all transaction.
// - Read starts on sync, no lockout, no repeat-read inhibit, address in space.
// - Cycle start delayed 80 ns only for internal refresh cycles.
// - Access arriving during a refresh waits until the refresh finishes.
// - Refresh requested after an access start waits until that access completes.
// - Start sets row strobe flag; lockout from flag, cycle end, delay blocks starts.
// - Lockout extends past row strobe clear to give precharge time.
// - Non-refresh row strobe edge with sync sets go-inhibit, blocking reads until sync drops.
// - Four phases follow row strobe in order: mux, column, reply, cycle end.
// - Mux phase selects high address bits; chip selects assert unless refresh.
// - Column phase with row strobe asserts both column strobes.
// - Reply phase of non-refresh cycle pulses 30 ns, setting reply flag and drivers.
// - Cycle end clears row strobe, column strobes, timer and all phase outputs.
// - Reply flag clears on trailing edge of read or write strobe.
// - Write intent latched at address phase withholds sync start; row bits still routed.
// - Write starts on write strobe, no lockout, no reply pending, write permitted.
// - Received write strobe enables the byte write strobes during a write cycle.
// - Read-modify-write writes to the same latched address without new address phase.
// - Row address is bus bits 01-06, column address bits 07-12.
// - In byte writes address bit 0 suppresses the unaddressed byte strobe.
// - Supply not good suppresses both byte write strobes.
`ifndef DRAM_CYCLE_REGS_VH
`define DRAM_CYCLE_REGS_VH
`define DRC_CLK_PS          8000
`define DRC_REF_DELAY_NS    80
`define DRC_REPLY_PULSE_NS  30
`define DRC_MUX_NS          40
`define DRC_CAS_NS          80
`define DRC_REPLY_NS        120
`define DRC_OFF_NS          250
`define DRC_PRECHARGE_NS    100
`define DRC_ROW_LSB         1
`define DRC_ROW_MSB         6
`define DRC_COL_LSB         7
`define DRC_COL_MSB         12
`define DRC_BANK_LSB        13
`define DRC_BANK_MSB        14
`define DRC_SPACE_LSB       15
`define DRC_SPACE_MSB       17
`endif

// file: rtl/phase_timer.v
`default_nettype none
module phase_timer #(
    parameter CW    = 6,
    parameter MUX_T = 5,
    parameter CAS_T = 10,
    parameter RPL_T = 15,
    parameter OFF_T = 31
) (
    input  wire clk,
    input  wire reset,
    input  wire run,
    output wire mux_ph,
    output wire cas_ph,
    output wire rpl_ph,
    output wire end_ph
);
    reg  [CW-1:0] cnt_r;
    wire [CW-1:0] cnt_nxt;

    // Restarts from zero whenever the row strobe is off
    assign cnt_nxt = !run ? {CW{1'b0}} :
                     end_ph ? cnt_r : cnt_r + {{(CW-1){1'b0}}, 1'b1};

    always @(posedge clk) begin
        if (reset)
            cnt_r <= {CW{1'b0}};
        else
            cnt_r <= cnt_nxt;
    end

    assign mux_ph = run && (cnt_r >= MUX_T[CW-1:0]);
    assign cas_ph = run && (cnt_r >= CAS_T[CW-1:0]);
    assign rpl_ph = run && (cnt_r >= RPL_T[CW-1:0]);
    assign end_ph = run && (cnt_r >= OFF_T[CW-1:0]);
endmodule // phase_timer
`default_nettype wire

// file: rtl/dram_cycle_ctl.v
`include "dram_cycle_regs.vh"
`default_nettype none
module dram_cycle_ctl #(
    parameter MUX_CYC = (`DRC_MUX_NS * 1000 + `DRC_CLK_PS - 1) / `DRC_CLK_PS,
    parameter CAS_CYC = (`DRC_CAS_NS * 1000 + `DRC_CLK_PS - 1) / `DRC_CLK_PS,
    parameter RPL_CYC = (`DRC_REPLY_NS * 1000 + `DRC_CLK_PS - 1) / `DRC_CLK_PS,
    parameter OFF_CYC = (`DRC_OFF_NS * 1000 + `DRC_CLK_PS - 1) / `DRC_CLK_PS,
    parameter PRE_CYC = (`DRC_PRECHARGE_NS * 1000 + `DRC_CLK_PS - 1) / `DRC_CLK_PS
) (
    input  wire        MCLK,
    input  wire        RESET,
    input  wire [15:0] BDAL_IN,
    input  wire [1:0]  BAD_IN,
    output reg  [15:0] BDAL_OUT,
    output wire        BDAL_OE,
    input  wire        BSYNC_N,
    input  wire        BDIN_N,
    input  wire        BDOUT_N,
    input  wire        BWTBT_N,
    output wire        BRPLY_N_OUT,
    output wire        BRPLY_N_OE,
    input  wire        SUPPLY_GOOD,
    input  wire        WRITE_PERMIT,
    input  wire [2:0]  SPACE_SELECT,
    input  wire        REFRESH_REQ,
    input  wire [5:0]  REFRESH_ROW,
    input  wire [15:0] ARRAY_READ_WORD,
    output reg  [15:0] ARRAY_WRITE_WORD,
    output reg  [5:0]  ARRAY_ADDR,
    output reg  [3:0]  ROW_STROBE_N,
    output reg         COLUMN_STROBE_A_N,
    output reg         COLUMN_STROBE_B_N,
    output reg         CHIP_SELECT_A_N,
    output reg         CHIP_SELECT_B_N,
    output reg         LOW_BYTE_WRITE_STROBE_N,
    output reg         HIGH_BYTE_WRITE_STROBE_N,
    output wire        INTERNAL_REFRESH_ACTIVE
);
    localparam REF_DLY_CYC = (`DRC_REF_DELAY_NS * 1000 + `DRC_CLK_PS - 1) / `DRC_CLK_PS;
    localparam PULSE_CYC   = (`DRC_REPLY_PULSE_NS * 1000 + `DRC_CLK_PS - 1) / `DRC_CLK_PS;

    // Start delay states
    localparam ST_IDLE  = 2'b00;
    localparam ST_DELAY = 2'b01;
    localparam ST_RUN   = 2'b10;

    function [3:0] bank_decode;
        input [1:0] sel;
        input       all;
        begin
            bank_decode = all ? 4'hF : (4'h1 << sel);
        end
    endfunction

    // Two-stage synchronisers for all asynchronous bus pins
    reg  [22:0] meta_r;
    reg  [22:0] pin_r;
    wire [22:0] pin_raw = {~BSYNC_N, ~BDIN_N, ~BDOUT_N, ~BWTBT_N, SUPPLY_GOOD, BAD_IN, BDAL_IN[15:1],
                           BDAL_IN[0]};
    always @(posedge MCLK) begin
        if (RESET) begin
            meta_r <= 23'h000000;
            pin_r  <= 23'h000000;
        end else begin
            meta_r <= pin_raw;
            pin_r  <= meta_r;
        end
    end

    wire        sync_received        = pin_r[22];
    wire        read_strobe_received  = pin_r[21];
    wire        write_strobe_received = pin_r[20];
    wire        wtbt_s               = pin_r[19];
    wire        supply_good          = pin_r[18];
    wire [17:0] addr_s               = pin_r[17:0];
    wire [15:0] data_s               = pin_r[15:0];

    reg        sync_d_r;
    reg        strobe_d_r;
    reg        rs_d_r;
    reg        rpl_d_r;
    reg [17:0] lat_addr_r;
    reg        latched_write_intent_r;
    reg        byte_write_r;
    reg        write_cycle_r;
    reg        row_strobe_flag_r;
    reg        internal_refresh_active_r;
    reg        refresh_pending_r;
    reg        go_inhibit_r;
    reg        reply_flag_r;
    reg [1:0]  st_r;
    reg [3:0]  dly_r;
    reg [4:0]  pre_r;
    reg [2:0]  pulse_r;

    wire high_addr_select;
    wire cas_phase;
    wire reply_phase;
    wire cycle_end;

    // Upper address bits sit just above the data bits in the pin vector
    wire [17:0] lat_src = addr_s;

    wire sync_rise   = sync_received && !sync_d_r;
    wire strobe_any  = read_strobe_received || write_strobe_received;
    wire strobe_fall = strobe_d_r && !strobe_any;
    wire rs_rise     = row_strobe_flag_r && !rs_d_r;
    wire rpl_rise    = reply_phase && !rpl_d_r;

    wire module_selected = sync_received &&
        (lat_addr_r[`DRC_SPACE_MSB:`DRC_SPACE_LSB] == SPACE_SELECT);

    // Precharge tail keeps the lockout up after the row strobe drops
    wire lockout = row_strobe_flag_r || cycle_end || (pre_r != 5'h00) ||
                   (st_r != ST_IDLE);

    // Held off in the sync edge cycle, while the latch still holds the last address
    wire read_go  = sync_received && !sync_rise && !lockout && !go_inhibit_r &&
                    module_selected && !latched_write_intent_r && !reply_flag_r &&
                    !write_strobe_received;
    wire write_go = write_strobe_received && !lockout && !reply_flag_r && WRITE_PERMIT &&
                    module_selected;
    wire access_go = read_go || write_go;
    // Accesses win a tie, so a late refresh request waits a whole cycle
    wire refresh_go = refresh_pending_r && !lockout && !reply_flag_r && !access_go;
    wire cycle_go   = access_go || refresh_go;

    always @(posedge MCLK) begin
        if (RESET) begin
            sync_d_r   <= 1'b0;
            strobe_d_r <= 1'b0;
            rs_d_r     <= 1'b0;
            rpl_d_r    <= 1'b0;
        end else begin
            sync_d_r   <= sync_received;
            strobe_d_r <= strobe_any;
            rs_d_r     <= row_strobe_flag_r;
            rpl_d_r    <= reply_phase;
        end
    end

    // Address and write intent held from the sync edge to the end of the transaction
    always @(posedge MCLK) begin
        if (RESET) begin
            lat_addr_r             <= 18'h00000;
            latched_write_intent_r <= 1'b0;
        end else if (sync_rise) begin
            lat_addr_r             <= lat_src;
            latched_write_intent_r <= wtbt_s;
        end else if (!sync_received) begin
            latched_write_intent_r <= 1'b0;
        end
    end

    // Byte width is taken from the write-byte line at data time
    always @(posedge MCLK) begin
        if (RESET) begin
            byte_write_r     <= 1'b0;
            write_cycle_r    <= 1'b0;
            ARRAY_WRITE_WORD <= 16'h0000;
        end else if (cycle_go) begin
            byte_write_r     <= write_go && wtbt_s;
            write_cycle_r    <= write_go;
            ARRAY_WRITE_WORD <= data_s;
        end
    end

    // Start path: refresh waits out the settling delay, accesses go straight through
    always @(posedge MCLK) begin
        if (RESET) begin
            st_r  <= ST_IDLE;
            dly_r <= 4'h0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (refresh_go) begin
                        st_r  <= ST_DELAY;
                        dly_r <= REF_DLY_CYC[3:0];
                    end else if (access_go) begin
                        st_r <= ST_RUN;
                    end
                end
                ST_DELAY: begin
                    if (dly_r == 4'h1)
                        st_r <= ST_RUN;
                    dly_r <= dly_r - 4'h1;
                end
                ST_RUN: begin
                    st_r <= ST_IDLE;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge MCLK) begin
        if (RESET) begin
            row_strobe_flag_r <= 1'b0;
            pre_r             <= 5'h00;
        end else if (cycle_end) begin
            row_strobe_flag_r <= 1'b0;
            pre_r             <= PRE_CYC[4:0];
        end else begin
            if (st_r == ST_RUN)
                row_strobe_flag_r <= 1'b1;
            if (pre_r != 5'h00)
                pre_r <= pre_r - 5'h01;
        end
    end

    always @(posedge MCLK) begin
        if (RESET) begin
            internal_refresh_active_r <= 1'b0;
            refresh_pending_r         <= 1'b0;
        end else begin
            if (refresh_go)
                internal_refresh_active_r <= 1'b1;
            else if (cycle_end)
                internal_refresh_active_r <= 1'b0;
            // New request wins over the clear by a taken refresh
            if (REFRESH_REQ)
                refresh_pending_r <= 1'b1;
            else if (refresh_go)
                refresh_pending_r <= 1'b0;
        end
    end

    always @(posedge MCLK) begin
        if (RESET)
            go_inhibit_r <= 1'b0;
        else if (rs_rise && !internal_refresh_active_r && sync_received)
            go_inhibit_r <= 1'b1;
        else if (!sync_received)
            go_inhibit_r <= 1'b0;
    end

    // Reply pulse stands in for the one-shot; set wins over a same-cycle clear
    always @(posedge MCLK) begin
        if (RESET) begin
            pulse_r      <= 3'h0;
            reply_flag_r <= 1'b0;
            BDAL_OUT     <= 16'h0000;
        end else begin
            if (rpl_rise && !internal_refresh_active_r)
                pulse_r <= PULSE_CYC[2:0];
            else if (pulse_r != 3'h0)
                pulse_r <= pulse_r - 3'h1;
            if (pulse_r != 3'h0) begin
                reply_flag_r <= 1'b1;
                BDAL_OUT     <= ARRAY_READ_WORD;
            end else if (strobe_fall) begin
                reply_flag_r <= 1'b0;
            end
        end
    end

    phase_timer #(
        .CW    (6),
        .MUX_T (MUX_CYC),
        .CAS_T (CAS_CYC),
        .RPL_T (RPL_CYC),
        .OFF_T (OFF_CYC)
    ) u_timer (
        .clk    (MCLK),
        .reset  (RESET),
        .run    (row_strobe_flag_r),
        .mux_ph (high_addr_select),
        .cas_ph (cas_phase),
        .rpl_ph (reply_phase),
        .end_ph (cycle_end)
    );

    wire non_ref = !internal_refresh_active_r;
    wire wr_en   = write_cycle_r && write_strobe_received && high_addr_select && non_ref &&
                   supply_good;
    reg  [5:0] addr_nxt;

    always @* begin
        if (internal_refresh_active_r)
            addr_nxt = high_addr_select ? 6'h00 : REFRESH_ROW;
        else if (high_addr_select)
            addr_nxt = lat_addr_r[`DRC_COL_MSB:`DRC_COL_LSB];
        else
            addr_nxt = lat_addr_r[`DRC_ROW_MSB:`DRC_ROW_LSB];
    end

    // Array pins registered to keep them glitch free
    always @(posedge MCLK) begin
        if (RESET) begin
            ARRAY_ADDR               <= 6'h00;
            ROW_STROBE_N             <= 4'hF;
            COLUMN_STROBE_A_N        <= 1'b1;
            COLUMN_STROBE_B_N        <= 1'b1;
            CHIP_SELECT_A_N          <= 1'b1;
            CHIP_SELECT_B_N          <= 1'b1;
            LOW_BYTE_WRITE_STROBE_N  <= 1'b1;
            HIGH_BYTE_WRITE_STROBE_N <= 1'b1;
        end else begin
            ARRAY_ADDR               <= addr_nxt;
            ROW_STROBE_N             <= row_strobe_flag_r ?
                ~bank_decode(lat_addr_r[`DRC_BANK_MSB:`DRC_BANK_LSB], !non_ref) : 4'hF;
            COLUMN_STROBE_A_N        <= !(cas_phase && row_strobe_flag_r);
            COLUMN_STROBE_B_N        <= !(cas_phase && row_strobe_flag_r);
            CHIP_SELECT_A_N          <= !(high_addr_select && non_ref);
            CHIP_SELECT_B_N          <= !(high_addr_select && non_ref);
            LOW_BYTE_WRITE_STROBE_N  <= !(wr_en && !(byte_write_r && lat_addr_r[0]));
            HIGH_BYTE_WRITE_STROBE_N <= !(wr_en && !(byte_write_r && !lat_addr_r[0]));
        end
    end

    // Reply line is open drain: pull low only
    assign BRPLY_N_OUT = 1'b0;
    assign BRPLY_N_OE  = reply_flag_r;
    assign BDAL_OE     = reply_flag_r && read_strobe_received && !write_cycle_r;
    assign INTERNAL_REFRESH_ACTIVE = internal_refresh_active_r;
endmodule // dram_cycle_ctl
`default_nettype wire

// file: verif/dram_cycle_monitor.sv
`default_nettype none
module dram_cycle_monitor #(
    parameter int PRE_CYC = 13
) (
    input wire logic       MCLK,
    input wire logic       RESET,
    input wire logic       BDAL_OE,
    input wire logic       BDIN_N,
    input wire logic       BDOUT_N,
    input wire logic       BRPLY_N_OE,
    input wire logic       SUPPLY_GOOD,
    input wire logic [3:0] ROW_STROBE_N,
    input wire logic       COLUMN_STROBE_A_N,
    input wire logic       COLUMN_STROBE_B_N,
    input wire logic       CHIP_SELECT_A_N,
    input wire logic       CHIP_SELECT_B_N,
    input wire logic       LOW_BYTE_WRITE_STROBE_N,
    input wire logic       HIGH_BYTE_WRITE_STROBE_N,
    input wire logic       INTERNAL_REFRESH_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] gap_r;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Saturates so a long idle never wraps into a false short gap
    always @(posedge MCLK) begin
        gap_r <= RESET ? 5'h1F : (ROW_STROBE_N != 4'hF) ? 5'h00 : gap_r + 5'(gap_r != 5'h1F);
    end
    AST_REFRESH_NO_REPLY: assert property (
        INTERNAL_REFRESH_ACTIVE |-> !BRPLY_N_OE) else $error("reply during refresh");
    AST_REFRESH_NO_CS: assert property (
        INTERNAL_REFRESH_ACTIVE |-> CHIP_SELECT_A_N && CHIP_SELECT_B_N)
        else $error("chip select during refresh");
    AST_STROBE_PAIRS: assert property (
        COLUMN_STROBE_A_N == COLUMN_STROBE_B_N && CHIP_SELECT_A_N == CHIP_SELECT_B_N)
        else $error("duplicate strobes differ");
    AST_COL_UNDER_ROW: assert property (
        !COLUMN_STROBE_A_N |-> ROW_STROBE_N != 4'hF) else $error("column without row");
    AST_ROW_BEFORE_COL: assert property (
        $fell(COLUMN_STROBE_A_N) |-> $past(ROW_STROBE_N, 4) != 4'hF)
        else $error("column too soon after row");
    AST_REPLY_AFTER_COL: assert property (
        $rose(BRPLY_N_OE) |-> !COLUMN_STROBE_A_N && !$past(COLUMN_STROBE_A_N, 4))
        else $error("reply too soon after column");
    AST_DATA_WITH_REPLY: assert property (
        BDAL_OE |-> BRPLY_N_OE) else $error("data driven without reply");
    AST_REPLY_RELEASE: assert property (
        $fell(BRPLY_N_OE) |-> $past(BDIN_N, 2) && $past(BDOUT_N, 2))
        else $error("reply released while strobe held");
    AST_SUPPLY_BLOCKS_WRITE: assert property (
        (!SUPPLY_GOOD) [*5] |-> LOW_BYTE_WRITE_STROBE_N && HIGH_BYTE_WRITE_STROBE_N)
        else $error("write strobe with bad supply");
    AST_PRECHARGE_GAP: assert property (
        $fell(ROW_STROBE_N == 4'hF) |-> gap_r >= PRE_CYC) else $error("precharge gap short");
endmodule // dram_cycle_monitor
bind dram_cycle_ctl dram_cycle_monitor #(.PRE_CYC(PRE_CYC)) u_dram_cycle_monitor (
    .MCLK, .RESET, .BDAL_OE, .BDIN_N, .BDOUT_N, .BRPLY_N_OE, .SUPPLY_GOOD, .ROW_STROBE_N,
    .COLUMN_STROBE_A_N, .COLUMN_STROBE_B_N, .CHIP_SELECT_A_N, .CHIP_SELECT_B_N,
    .LOW_BYTE_WRITE_STROBE_N, .HIGH_BYTE_WRITE_STROBE_N, .INTERNAL_REFRESH_ACTIVE
);
`default_nettype wire

// file: verif/bus_master_model.sv
`default_nettype none
module bus_master_model (
    input  wire logic        clk,
    input  wire logic        brply_n_oe,
    output var  logic [15:0] bdal,
    output var  logic [1:0]  bad,
    output var  logic        sync_n,
    output var  logic        din_n,
    output var  logic        dout_n,
    output var  logic        wtbt_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {bdal, bad} = 18'h00000;
        {sync_n, din_n, dout_n, wtbt_n} = 4'hF;
    end
    task automatic open_cycle(input logic [17:0] a, input logic w);
        @(posedge clk);
        {bad, bdal} <= a;
        wtbt_n <= ~w;
        @(posedge clk);
        sync_n <= 1'b0;
        repeat (3) @(posedge clk);
        // Released lines show the inverse so a stale latch is caught
        {bad, bdal} <= ~a;
        wtbt_n <= 1'b1;
    endtask
    task automatic xfer(input logic rd, input logic [15:0] d, input logic byt, output logic got);
        got = 1'b0;
        @(posedge clk);
        if (!rd) begin
            bdal <= d;
            wtbt_n <= ~byt;
        end
        din_n <= ~rd;
        dout_n <= rd;
        for (int i = 0; i < 120 && !got; i++) begin
            @(posedge clk);
            got = (brply_n_oe === 1'b1);
        end
        {din_n, dout_n, wtbt_n} <= 3'h7;
        bdal <= ~d;
        for (int i = 0; i < 20 && brply_n_oe !== 1'b0; i++) @(posedge clk);
    endtask
    task automatic close_cycle();
        @(posedge clk);
        sync_n <= 1'b1;
        repeat (40) @(posedge clk);
    endtask
endmodule // bus_master_model
`default_nettype wire

// file: verif/async_bus_dram_cycle_control_bench.sv
`default_nettype none
module async_bus_dram_cycle_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 0, RESET = 1, SUPPLY_GOOD = 1, WRITE_PERMIT = 1, REFRESH_REQ = 0;
    logic [2:0] SPACE_SELECT = 3'h2;
    logic [5:0] REFRESH_ROW = 6'h2A, ARRAY_ADDR, row_seen, col_seen;
    logic [15:0] ARRAY_READ_WORD = 16'hC35A, BDAL_IN, BDAL_OUT, ARRAY_WRITE_WORD, rd_seen;
    logic [1:0] BAD_IN;
    logic [3:0] ROW_STROBE_N, ras_prev, ras_seen;
    logic BSYNC_N, BDIN_N, BDOUT_N, BWTBT_N, BDAL_OE, BRPLY_N_OE, cas_prev, rpl_prev;
    logic COLUMN_STROBE_A_N, COLUMN_STROBE_B_N, CHIP_SELECT_A_N, CHIP_SELECT_B_N, BRPLY_N_OUT;
    logic LOW_BYTE_WRITE_STROBE_N, HIGH_BYTE_WRITE_STROBE_N, INTERNAL_REFRESH_ACTIVE;
    int err_count = 0, checked = 0, cyc = 0, t_ras = 0, ras_n = 0, rpl_n = 0, lo_n = 0, hi_n = 0;
    dram_cycle_ctl u_dram_cycle_ctl (.MCLK, .RESET, .BDAL_IN, .BAD_IN, .BDAL_OUT, .BDAL_OE,
        .BSYNC_N, .BDIN_N, .BDOUT_N, .BWTBT_N, .BRPLY_N_OUT, .BRPLY_N_OE, .SUPPLY_GOOD,
        .WRITE_PERMIT, .SPACE_SELECT, .REFRESH_REQ, .REFRESH_ROW, .ARRAY_READ_WORD,
        .ARRAY_WRITE_WORD, .ARRAY_ADDR, .ROW_STROBE_N, .COLUMN_STROBE_A_N, .COLUMN_STROBE_B_N,
        .CHIP_SELECT_A_N, .CHIP_SELECT_B_N, .LOW_BYTE_WRITE_STROBE_N, .HIGH_BYTE_WRITE_STROBE_N,
        .INTERNAL_REFRESH_ACTIVE);
    bus_master_model u_bus_master_model (.clk(MCLK), .brply_n_oe(BRPLY_N_OE), .bdal(BDAL_IN),
        .bad(BAD_IN), .sync_n(BSYNC_N), .din_n(BDIN_N), .dout_n(BDOUT_N), .wtbt_n(BWTBT_N));
    always #4 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        {ras_prev, cas_prev, rpl_prev} <= {ROW_STROBE_N, COLUMN_STROBE_A_N, BRPLY_N_OE};
        if (ras_prev == 4'hF && ROW_STROBE_N != 4'hF) begin
            {ras_seen, row_seen, t_ras, ras_n} <= {ROW_STROBE_N, ARRAY_ADDR, cyc, ras_n + 1};
        end
        if (cas_prev && !COLUMN_STROBE_A_N) col_seen <= ARRAY_ADDR;
        if (!rpl_prev && BRPLY_N_OE) rpl_n <= rpl_n + 1;
        if (BDAL_OE === 1'b1) rd_seen <= BDAL_OUT;
        lo_n <= lo_n + (LOW_BYTE_WRITE_STROBE_N === 1'b0);
        hi_n <= hi_n + (HIGH_BYTE_WRITE_STROBE_N === 1'b0);
    end
    function automatic logic [17:0] adr(input logic b0);
        return {3'h2, 2'h2, 6'h2D, 6'h13, b0};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic access(input logic [17:0] a, input logic rd, input logic byt, output logic got);
        u_bus_master_model.open_cycle(a, !rd);
        u_bus_master_model.xfer(rd, 16'h1234, byt, got);
        u_bus_master_model.close_cycle();
    endtask
    task automatic t_read_rmw();
        logic got;
        int lo0, hi0;
        u_bus_master_model.open_cycle(adr(1), 1'b0);
        u_bus_master_model.xfer(1'b1, 16'h0000, 1'b0, got);
        check("read reply", got, 1);
        check("reply level", BRPLY_N_OUT, 0);
        check("read data", rd_seen, 16'hC35A);
        check("bank", ras_seen, 4'hB);
        check("row addr", row_seen, 6'h13);
        check("col addr", col_seen, 6'h2D);
        u_bus_master_model.xfer(1'b1, 16'h0000, 1'b0, got);
        check("repeat read", got, 0);
        {lo0, hi0} = {lo_n, hi_n};
        u_bus_master_model.xfer(1'b0, 16'h7E81, 1'b1, got);
        check("rmw reply", got, 1);
        check("rmw data", ARRAY_WRITE_WORD, 16'h7E81);
        check("rmw strobes", {hi_n != hi0, lo_n != lo0}, 2'b10);
        u_bus_master_model.close_cycle();
    endtask
    task automatic t_writes();
        logic got;
        int lo0, hi0, r0;
        logic [1:0] exp_wb[3] = '{2'b11, 2'b01, 2'b10};
        for (int k = 0; k < 3; k++) begin
            {lo0, hi0, r0} = {lo_n, hi_n, ras_n};
            u_bus_master_model.open_cycle(adr(k == 2), 1'b1);
            repeat (20) @(posedge MCLK);
            check("start on sync", ras_n, r0);
            check("row routed", ARRAY_ADDR, 6'h13);
            u_bus_master_model.xfer(1'b0, 16'hA0F0 + 16'(k), k != 0, got);
            check("write reply", got, 1);
            check("write data", ARRAY_WRITE_WORD, 16'hA0F0 + 16'(k));
            check("strobes", {hi_n != hi0, lo_n != lo0}, exp_wb[k]);
            u_bus_master_model.close_cycle();
        end
    endtask
    task automatic t_refused();
        logic got;
        int lo0;
        @(posedge MCLK) WRITE_PERMIT <= 1'b0;
        access(adr(0), 1'b0, 1'b0, got);
        check("write not permitted", got, 0);
        @(posedge MCLK) {WRITE_PERMIT, SUPPLY_GOOD} <= 2'b10;
        lo0 = lo_n + hi_n;
        access(adr(0), 1'b0, 1'b0, got);
        check("supply strobes", lo_n + hi_n, lo0);
        @(posedge MCLK) SUPPLY_GOOD <= 1'b1;
        access(adr(0) ^ 18'h38000, 1'b1, 1'b0, got);
        check("outside space", got, 0);
    endtask
    task automatic t_refresh();
        logic got;
        int t0, r0;
        {r0, t0} = {rpl_n, cyc};
        @(posedge MCLK) REFRESH_REQ <= 1'b1;
        @(posedge MCLK) REFRESH_REQ <= 1'b0;
        repeat (60) @(posedge MCLK);
        check("refresh banks", ras_seen, 4'h0);
        check("refresh row", row_seen, 6'h2A);
        check("refresh reply", rpl_n, r0);
        check("refresh delay", t_ras - t0 >= 11, 1);
        r0 = ras_n;
        fork
            access(adr(0), 1'b1, 1'b0, got);
            begin
                // Request lands after the read has already started
                repeat (8) @(posedge MCLK);
                REFRESH_REQ <= 1'b1;
                @(posedge MCLK) REFRESH_REQ <= 1'b0;
            end
        join
        repeat (60) @(posedge MCLK);
        check("read before refresh", got, 1);
        check("refresh after read", ras_n - r0, 2);
        check("refresh is last", ras_seen, 4'h0);
        fork
            access(adr(0), 1'b1, 1'b0, got);
            @(posedge MCLK) REFRESH_REQ <= 1'b1;
        join_any
        @(posedge MCLK) REFRESH_REQ <= 1'b0;
        wait fork;
        check("read after refresh", got, 1);
        check("last is read", ras_seen, 4'hB);
    endtask
    task automatic conclude();
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge MCLK);
        err_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge MCLK);
        RESET <= 1'b0;
        t_read_rmw();
        t_writes();
        t_refused();
        t_refresh();
        conclude();
    end
endmodule // async_bus_dram_cycle_control_bench
`default_nettype wire
